// ==== include/als_upper_threshold_and_led_current_map.svh ====
// Purpose: register offsets, field positions and reset values of the
//          upper ambient threshold and emitter current register slice
// Assumes: byte-wide registers on the device's internal register port
// Notes:   definitions only
//
// What this block does
// RULE1: upper ambient threshold is one 16-bit value, low byte 0x0d, high byte 0x0e.
// RULE2: upper and lower thresholds form a window over visible or infrared result.
// RULE3: host pauses ambient or combined measurements before changing the upper threshold; host_model waits at most 50 cycles, then writes.
// RULE4: on old silicon the upper threshold is an 8-bit compressed value.
// RULE5: upper threshold registers exist only with a new enough sequencer.
// RULE6: bits 7:4 at 0x0f set the second emitter sink current.
// RULE7: single-emitter parts keep the second emitter field at zero.
// RULE8: bits 3:0 at 0x0f set the first emitter sink current.
// RULE9: code 0000 is no drive, 0001 minimum, up to 1111 maximum.
// RULE10: bits 3:0 at 0x10 set the third emitter sink current.
// RULE11: single and dual emitter parts keep the third emitter field at zero.
// RULE12: bits 7:4 at 0x10 read as zero and ignore writes.
`ifndef ALS_UPPER_THRESHOLD_AND_LED_CURRENT_MAP_SVH
`define ALS_UPPER_THRESHOLD_AND_LED_CURRENT_MAP_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define UPPER_THRESHOLD_LOW_OFFSET   8'h0d
`define UPPER_THRESHOLD_HIGH_OFFSET  8'h0e
`define EMITTER_FIRST_SECOND_OFFSET  8'h0f
`define EMITTER_THIRD_OFFSET         8'h10

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define UPPER_THRESHOLD_RESET        16'h0000
`define EMITTER_CURRENT_RESET        4'h0
`define READ_DATA_RESET              8'h00

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define EMITTER_TWO_MSB              7
`define EMITTER_TWO_LSB              4
`define EMITTER_ONE_MSB              3
`define EMITTER_ONE_LSB              0
`define EMITTER_THREE_MSB            3
`define EMITTER_THREE_LSB            0

// ----------------------------------------------------------------------------
// compressed threshold format
// ----------------------------------------------------------------------------
`define COMPRESSED_FRACTION_BITS     4

`endif

// ==== include/als_upper_threshold_and_led_current_pkg.sv ====
// Purpose: shared types of the threshold and emitter current slice
// Assumes: offsets and fields come from the _map header
// Notes:   types only
package als_upper_threshold_and_led_current_pkg;

   typedef logic [7:0]  reg_byte_t;
   typedef logic [15:0] threshold_t;
   typedef logic [3:0]  drive_code_t;

   // which ambient result the window watches
   typedef enum logic [1:0]
   {
      SOURCE_VISIBLE  = 2'b01,
      SOURCE_INFRARED = 2'b10
   } ambient_source_t;

endpackage

// ==== include/ambient_window_if.sv ====
// Purpose: carries thresholds and the selected result to the window compare
// Assumes: single clock domain, purely combinational compare
// Notes:   one modport per side
`timescale 1ns/1ps

interface ambient_window_if;
   als_upper_threshold_and_led_current_pkg::threshold_t upper_threshold;
   als_upper_threshold_and_led_current_pkg::threshold_t lower_threshold;
   logic                                                 upper_present;
   logic                                                 compressed_format;
   als_upper_threshold_and_led_current_pkg::threshold_t result;
   logic                                                 outside;

   modport regs
   (
      output upper_threshold,
      output lower_threshold,
      output upper_present,
      output compressed_format,
      output result,
      input  outside
   );

   modport compare
   (
      input  upper_threshold,
      input  lower_threshold,
      input  upper_present,
      input  compressed_format,
      input  result,
      output outside
   );
endinterface // ambient_window_if

// ==== rtl/ambient_window_compare.sv ====
// Purpose: decides whether an ambient result lies outside the threshold window
// Assumes: thresholds and result stable for the cycle they are compared in
// Notes:   combinational; the caller registers the verdict
`timescale 1ns/1ps
`include "als_upper_threshold_and_led_current_map.svh"

module ambient_window_compare
(
   ambient_window_if.compare win
);

   // ----------------------------------------------------------------------------
   // compressed threshold expansion
   // ----------------------------------------------------------------------------
   // high nibble is the exponent, low nibble the fraction below a hidden one
   function automatic als_upper_threshold_and_led_current_pkg::threshold_t expand
   (
      input als_upper_threshold_and_led_current_pkg::reg_byte_t code
   );
      logic [31:0] wide;
      wide = {27'h0, 1'b1, code[3:0]} << code[7:4];
      if (code == 8'h00)
         expand = 16'h0000;
      else
         expand = wide[`COMPRESSED_FRACTION_BITS +: 16];
   endfunction

   // ----------------------------------------------------------------------------
   // window
   // ----------------------------------------------------------------------------
   als_upper_threshold_and_led_current_pkg::threshold_t eff_upper;
   als_upper_threshold_and_led_current_pkg::threshold_t eff_lower;

   always_comb
   begin
      if (!win.upper_present)
         eff_upper = 16'hffff;                                   // RULE5
      else if (win.compressed_format)
         eff_upper = expand(win.upper_threshold[7:0]);           // RULE4
      else
         eff_upper = win.upper_threshold;                        // RULE1
      if (win.compressed_format)
         eff_lower = expand(win.lower_threshold[7:0]);
      else
         eff_lower = win.lower_threshold;
   end

   assign win.outside = (win.result > eff_upper) || (win.result < eff_lower); // RULE2

endmodule // ambient_window_compare

// ==== rtl/als_upper_threshold_and_led_current_regs.sv ====
// Purpose: upper ambient threshold and emitter current registers, with the
//          window verdict and per-emitter sink currents they steer
// Assumes: register port driven by the serial slave on the same clock
// Notes:   revision inputs are static configuration levels
`timescale 1ns/1ps
`include "als_upper_threshold_and_led_current_map.svh"

module als_upper_threshold_and_led_current_regs
(
   // clock and reset
   input  wire logic                                                 I_CLK,
   input  wire logic                                                 I_RST,
   input  wire logic                                                 I_CE,
   // register port
   input  wire logic                                                 I_WR_EN,
   input  wire logic                                                 I_RD_EN,
   input  wire als_upper_threshold_and_led_current_pkg::reg_byte_t   I_ADDR,
   input  wire als_upper_threshold_and_led_current_pkg::reg_byte_t   I_WDATA,
   output      als_upper_threshold_and_led_current_pkg::reg_byte_t   O_RDATA,
   output      logic                                                 O_RDATA_VALID,
   // revision configuration
   input  wire logic                                                 I_SEQ_REV_A03_OR_LATER,
   input  wire logic                                                 I_REV_A10_OR_EARLIER,
   // ambient window
   input  wire als_upper_threshold_and_led_current_pkg::threshold_t  I_AMBIENT_LOWER_THRESHOLD,
   input  wire als_upper_threshold_and_led_current_pkg::threshold_t  I_VISIBLE_LIGHT_RESULT,
   input  wire als_upper_threshold_and_led_current_pkg::threshold_t  I_INFRARED_LIGHT_RESULT,
   input  wire logic                                                 I_USE_INFRARED,
   input  wire logic                                                 I_RESULT_VALID,
   output      logic                                                 O_WINDOW_EVENT,
   output      als_upper_threshold_and_led_current_pkg::threshold_t  O_AMBIENT_UPPER_THRESHOLD,
   // emitters
   input  wire logic                                                 I_PROXIMITY_ACTIVE,
   output      als_upper_threshold_and_led_current_pkg::drive_code_t O_EMITTER_ONE_SINK,
   output      als_upper_threshold_and_led_current_pkg::drive_code_t O_EMITTER_TWO_SINK,
   output      als_upper_threshold_and_led_current_pkg::drive_code_t O_EMITTER_THREE_SINK
);

   // ----------------------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------------------
   function automatic logic hit
   (
      input als_upper_threshold_and_led_current_pkg::reg_byte_t addr,
      input als_upper_threshold_and_led_current_pkg::reg_byte_t offset
   );
      hit = (addr == offset);
   endfunction

   function automatic logic upper_addr
   (
      input als_upper_threshold_and_led_current_pkg::reg_byte_t addr
   );
      upper_addr = hit(addr, `UPPER_THRESHOLD_LOW_OFFSET) || hit(addr, `UPPER_THRESHOLD_HIGH_OFFSET);
   endfunction

   // ----------------------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------------------
   als_upper_threshold_and_led_current_pkg::threshold_t     upper_threshold;
   als_upper_threshold_and_led_current_pkg::drive_code_t    emitter_one_current;
   als_upper_threshold_and_led_current_pkg::drive_code_t    emitter_two_current;
   als_upper_threshold_and_led_current_pkg::drive_code_t    emitter_three_current;
   als_upper_threshold_and_led_current_pkg::reg_byte_t      next_rdata;
   als_upper_threshold_and_led_current_pkg::ambient_source_t source;
   als_upper_threshold_and_led_current_pkg::threshold_t     selected_result;

   logic write_ok;
   logic upper_writable;

   assign write_ok       = I_CE && I_WR_EN;
   assign upper_writable = write_ok && I_SEQ_REV_A03_OR_LATER;                    // RULE5

   // ----------------------------------------------------------------------------
   // upper ambient threshold
   // ----------------------------------------------------------------------------
   always_ff @(posedge I_CLK or posedge I_RST)
   begin
      if (I_RST)
         upper_threshold <= `UPPER_THRESHOLD_RESET;
      else if (upper_writable && hit(I_ADDR, `UPPER_THRESHOLD_LOW_OFFSET))
         upper_threshold[7:0] <= I_WDATA;                                        // RULE1
      else if (upper_writable && hit(I_ADDR, `UPPER_THRESHOLD_HIGH_OFFSET))
         upper_threshold[15:8] <= I_WDATA;                                       // RULE1
   end

   always_ff @(posedge I_CLK or posedge I_RST)
   begin
      if (I_RST)
         O_AMBIENT_UPPER_THRESHOLD <= `UPPER_THRESHOLD_RESET;
      else if (I_CE)
         O_AMBIENT_UPPER_THRESHOLD <= upper_threshold;
   end

   // ----------------------------------------------------------------------------
   // emitter current fields
   // ----------------------------------------------------------------------------
   always_ff @(posedge I_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         emitter_one_current <= `EMITTER_CURRENT_RESET;
         emitter_two_current <= `EMITTER_CURRENT_RESET;
      end
      else if (write_ok && hit(I_ADDR, `EMITTER_FIRST_SECOND_OFFSET))
      begin
         emitter_one_current <= I_WDATA[`EMITTER_ONE_MSB:`EMITTER_ONE_LSB];      // RULE8
         emitter_two_current <= I_WDATA[`EMITTER_TWO_MSB:`EMITTER_TWO_LSB];      // RULE6
      end
   end

   // upper nibble is not stored at all
   always_ff @(posedge I_CLK or posedge I_RST)
   begin
      if (I_RST)
         emitter_three_current <= `EMITTER_CURRENT_RESET;
      else if (write_ok && hit(I_ADDR, `EMITTER_THIRD_OFFSET))
         emitter_three_current <= I_WDATA[`EMITTER_THREE_MSB:`EMITTER_THREE_LSB]; // RULE10
   end

   // ----------------------------------------------------------------------------
   // emitter sink drive
   // ----------------------------------------------------------------------------
   // codes reach the drivers only while I_PROXIMITY_ACTIVE, else zero; zero means no current
   always_ff @(posedge I_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         O_EMITTER_ONE_SINK   <= `EMITTER_CURRENT_RESET;
         O_EMITTER_TWO_SINK   <= `EMITTER_CURRENT_RESET;
         O_EMITTER_THREE_SINK <= `EMITTER_CURRENT_RESET;
      end
      else if (I_CE)
      begin
         O_EMITTER_ONE_SINK   <= I_PROXIMITY_ACTIVE ? emitter_one_current : 4'h0;   // RULE9
         O_EMITTER_TWO_SINK   <= I_PROXIMITY_ACTIVE ? emitter_two_current : 4'h0;   // RULE9
         O_EMITTER_THREE_SINK <= I_PROXIMITY_ACTIVE ? emitter_three_current : 4'h0; // RULE9
      end
   end

   // ----------------------------------------------------------------------------
   // read back
   // ----------------------------------------------------------------------------
   always_comb
   begin
      next_rdata = `READ_DATA_RESET;
      if (upper_addr(I_ADDR) && !I_SEQ_REV_A03_OR_LATER)
         next_rdata = 8'h00;                                                     // RULE5
      else if (hit(I_ADDR, `UPPER_THRESHOLD_LOW_OFFSET))
         next_rdata = upper_threshold[7:0];
      else if (hit(I_ADDR, `UPPER_THRESHOLD_HIGH_OFFSET))
         next_rdata = upper_threshold[15:8];
      else if (hit(I_ADDR, `EMITTER_FIRST_SECOND_OFFSET))
         next_rdata = {emitter_two_current, emitter_one_current};
      else if (hit(I_ADDR, `EMITTER_THIRD_OFFSET))
         next_rdata = {4'h0, emitter_three_current};                             // RULE12
   end

   always_ff @(posedge I_CLK or posedge I_RST)
   begin
      if (I_RST)
         O_RDATA <= `READ_DATA_RESET;
      else if (I_CE && I_RD_EN)
         O_RDATA <= next_rdata;
   end

   always_ff @(posedge I_CLK or posedge I_RST)
   begin
      if (I_RST)
         O_RDATA_VALID <= 1'b0;
      else if (I_CE)
         O_RDATA_VALID <= I_RD_EN;
   end

   // ----------------------------------------------------------------------------
   // window compare
   // ----------------------------------------------------------------------------
   ambient_window_if win ();

   assign source = I_USE_INFRARED ? als_upper_threshold_and_led_current_pkg::SOURCE_INFRARED
                                  : als_upper_threshold_and_led_current_pkg::SOURCE_VISIBLE;

   always_comb
   begin
      unique case (source)
         als_upper_threshold_and_led_current_pkg::SOURCE_VISIBLE:  selected_result = I_VISIBLE_LIGHT_RESULT;
         als_upper_threshold_and_led_current_pkg::SOURCE_INFRARED: selected_result = I_INFRARED_LIGHT_RESULT;
         default:                                                  selected_result = 16'h0000;
      endcase
   end

   assign win.upper_threshold   = upper_threshold;
   assign win.lower_threshold   = I_AMBIENT_LOWER_THRESHOLD;
   assign win.upper_present     = I_SEQ_REV_A03_OR_LATER;
   assign win.compressed_format = I_REV_A10_OR_EARLIER;
   assign win.result            = selected_result;

   ambient_window_compare compare
   (
      .win (win.compare)
   );

   always_ff @(posedge I_CLK or posedge I_RST)
   begin
      if (I_RST)
         O_WINDOW_EVENT <= 1'b0;
      else if (I_CE)
         O_WINDOW_EVENT <= I_RESULT_VALID && win.outside;                        // RULE2
   end

   // ----------------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------------
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (I_RST);

   sequence s_third_write;
      I_CE && I_WR_EN && !I_RD_EN && hit(I_ADDR, `EMITTER_THIRD_OFFSET);
   endsequence

   sequence s_third_read;
      I_CE && I_RD_EN && !I_WR_EN && hit(I_ADDR, `EMITTER_THIRD_OFFSET);
   endsequence

   a_upper_low_write: assert property ( // RULE1
      upper_writable && hit(I_ADDR, `UPPER_THRESHOLD_LOW_OFFSET)
      |=> ##1 O_AMBIENT_UPPER_THRESHOLD[7:0] == $past(I_WDATA, 2) || !$past(I_CE))
      else $error("upper threshold low byte not stored");

   a_upper_high_write: assert property ( // RULE1
      upper_writable && hit(I_ADDR, `UPPER_THRESHOLD_HIGH_OFFSET) |=> upper_threshold[15:8] == $past(I_WDATA))
      else $error("upper threshold high byte not stored");

   a_upper_absent_read: assert property ( // RULE5
      I_CE && I_RD_EN && upper_addr(I_ADDR) && !I_SEQ_REV_A03_OR_LATER |=> O_RDATA == 8'h00)
      else $error("absent upper threshold read nonzero");

   a_upper_absent_write: assert property ( // RULE5
      !I_SEQ_REV_A03_OR_LATER && I_WR_EN && upper_addr(I_ADDR) |=> $stable(upper_threshold))
      else $error("absent upper threshold took a write");

   a_window_event: assert property ( // RULE2
      I_CE && (I_RESULT_VALID && win.outside) |=> O_WINDOW_EVENT)
      else $error("outside result raised no event");

   a_window_quiet: assert property ( // RULE2
      I_CE && !I_RESULT_VALID |=> !O_WINDOW_EVENT)
      else $error("event without a result");

   a_compressed_zero: assert property ( // RULE4
      I_CE && I_RESULT_VALID && I_REV_A10_OR_EARLIER && I_SEQ_REV_A03_OR_LATER
      && upper_threshold[7:0] == 8'h00 && selected_result != 16'h0000 |=> O_WINDOW_EVENT)
      else $error("compressed zero upper threshold not applied");

   a_emitter_one_field: assert property ( // RULE8
      write_ok && hit(I_ADDR, `EMITTER_FIRST_SECOND_OFFSET) |=> emitter_one_current == $past(I_WDATA[3:0]))
      else $error("first emitter field wrong");

   a_emitter_two_field: assert property ( // RULE6
      write_ok && hit(I_ADDR, `EMITTER_FIRST_SECOND_OFFSET) |=> emitter_two_current == $past(I_WDATA[7:4]))
      else $error("second emitter field wrong");

   a_sink_idle_zero: assert property ( // RULE9
      I_CE && !I_PROXIMITY_ACTIVE |=> O_EMITTER_ONE_SINK == 4'h0 && O_EMITTER_TWO_SINK == 4'h0
      && O_EMITTER_THREE_SINK == 4'h0)
      else $error("emitter sinks current outside a measurement");

   a_sink_follows_code: assert property ( // RULE10
      I_CE && I_PROXIMITY_ACTIVE |=> O_EMITTER_THREE_SINK == $past(emitter_three_current))
      else $error("third emitter sink does not follow its code");

   a_third_round_trip: assert property ( // RULE12
      s_third_write ##1 s_third_read |=> O_RDATA == {4'h0, $past(I_WDATA[3:0], 2)})
      else $error("third emitter register read back wrong");

endmodule // als_upper_threshold_and_led_current_regs

// ==== testbench/host_model.sv ====
// Purpose: host side of the register port, behavioural
// Assumes: tasks are entered just after a falling clock edge
// Notes:   EMITTERS is the number of fitted emitters
`timescale 1ns/1ps

module host_model
#(
   parameter int EMITTERS = 3
)
(
   // clock and status
   input  wire logic       i_clk,
   input  wire logic       i_measuring,
   input  wire logic [7:0] i_rdata,
   input  wire logic       i_rdata_valid,
   // register port
   output      logic       o_wr_en,
   output      logic       o_rd_en,
   output      logic [7:0] o_addr,
   output      logic [7:0] o_wdata
);
   initial
   begin
      o_wr_en = 1'b0;
      o_rd_en = 1'b0;
      o_addr  = 8'hff;
      o_wdata = 8'h5a;
   end

   // --------------------------------------------------------------------
   // byte write, held through one rising edge
   // --------------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      if (a == 8'h0f && EMITTERS < 2)
         v[7:4] = 4'h0;
      if (a == 8'h10 && EMITTERS < 3)
         v[3:0] = 4'h0;
      for (int i = 0; i < 50 && i_measuring && a inside {8'h0d, 8'h0e}; i++)
         @(negedge i_clk);
      o_addr  = a;
      o_wdata = v;
      o_wr_en = 1'b1;
      @(negedge i_clk);
      o_wr_en = 1'b0;
      o_addr  = ~a;
      o_wdata = ~v;
      @(negedge i_clk);
   endtask

   // --------------------------------------------------------------------
   // byte read, waits a bounded time for the valid pulse
   // --------------------------------------------------------------------
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
      ok      = 1'b0;
      d       = 8'h00;
      o_addr  = a;
      o_rd_en = 1'b1;
      @(negedge i_clk);
      o_rd_en = 1'b0;
      o_addr  = ~a;
      for (int i = 0; i < 4 && !ok; i++)
      begin
         ok = (i_rdata_valid === 1'b1);
         d  = i_rdata;
         @(negedge i_clk);
      end
   endtask

   // --------------------------------------------------------------------
   // byte write, then a read of the same offset in the very next cycle
   // --------------------------------------------------------------------
   task automatic wr_rd(input logic [7:0] a, input logic [7:0] w, output logic [7:0] d, output logic ok);
      o_addr  = a;
      o_wdata = w;
      o_wr_en = 1'b1;
      @(negedge i_clk);
      o_wr_en = 1'b0;
      o_wdata = ~w;
      rd(a, d, ok);
   endtask
endmodule // host_model

// ==== testbench/als_upper_threshold_and_led_current_regs_bench.sv ====
// Purpose: self-checking bench of the threshold and emitter register slice
// Assumes: three-emitter variant, inputs driven on falling edges
// Notes:   host_model drives the register port
`timescale 1ns/1ps

module als_upper_threshold_and_led_current_regs_bench;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        ce = 1'b1;
   logic        wr_en, rd_en, rv, valid, seq, old, inf, prox;
   logic [7:0]  addr, wdata, rdata;
   logic [15:0] low = 16'h0010, vis = 16'h0000, ir = 16'h0000, upper;
   logic        event_out;
   logic [3:0]  s1, s2, s3;
   int          fails = 0, checked = 0;

   initial
   begin
      seq = 1'b1;
      old = 1'b0;
      inf = 1'b0;
      prox = 1'b0;
      valid = 1'b0;
   end

   initial
   forever #5 clk = ~clk;

   host_model #(.EMITTERS(3)) u_host_model
   (
      .i_clk(clk), .i_measuring(valid), .i_rdata(rdata), .i_rdata_valid(rv),
      .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata)
   );

   als_upper_threshold_and_led_current_regs u_als_upper_threshold_and_led_current_regs
   (
      .I_CLK(clk), .I_RST(rst), .I_CE(ce), .I_WR_EN(wr_en), .I_RD_EN(rd_en),
      .I_ADDR(addr), .I_WDATA(wdata), .O_RDATA(rdata), .O_RDATA_VALID(rv),
      .I_SEQ_REV_A03_OR_LATER(seq), .I_REV_A10_OR_EARLIER(old),
      .I_AMBIENT_LOWER_THRESHOLD(low), .I_VISIBLE_LIGHT_RESULT(vis),
      .I_INFRARED_LIGHT_RESULT(ir), .I_USE_INFRARED(inf), .I_RESULT_VALID(valid),
      .O_WINDOW_EVENT(event_out), .O_AMBIENT_UPPER_THRESHOLD(upper),
      .I_PROXIMITY_ACTIVE(prox), .O_EMITTER_ONE_SINK(s1),
      .O_EMITTER_TWO_SINK(s2), .O_EMITTER_THREE_SINK(s3)
   );

   // --------------------------------------------------------------------
   // comparisons and closing
   // --------------------------------------------------------------------
   task automatic end_sim();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e)
      begin
         fails++;
         $display("wrong value t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
      chk_word({8'h00, g}, {8'h00, e});
   endtask

   task automatic chk_bit(input logic g, input logic e);
      chk_word({15'h0000, g}, {15'h0000, e});
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic       ok;
      u_host_model.rd(a, d, ok);
      if (!ok)
      begin
         fails++;
         end_sim();
      end
      else
         chk_byte(d, e);
   endtask

   task automatic win(input logic i, input logic [15:0] v, input logic [15:0] r, input logic e);
      inf   = i;
      vis   = v;
      ir    = r;
      valid = 1'b1;
      @(negedge clk);
      chk_bit(event_out, e);
      valid = 1'b0;
      @(negedge clk);
      chk_bit(event_out, 1'b0);
   endtask

   task automatic emit(input logic [7:0] f12, input logic [7:0] f3);
      u_host_model.wr(8'h0f, f12);
      u_host_model.wr(8'h10, f3);
      prox = 1'b1;
      @(negedge clk);
      chk_byte({s2, s1}, f12);
      chk_byte({4'h0, s3}, {4'h0, f3[3:0]});
      prox = 1'b0;
      @(negedge clk);
      chk_word({4'h0, s3, s2, s1}, 16'h0000);
   endtask

   // --------------------------------------------------------------------
   // scenarios
   // --------------------------------------------------------------------
   task automatic t_reset();
      chk_word(upper, 16'h0000);
      for (int i = 0; i < 5; i++)
         rdchk(8'h0d + i[7:0], 8'h00);
      $display("test reset done");
   endtask

   task automatic t_emitters();
      logic [3:0] c [3] = '{4'h0, 4'h1, 4'hf};
      logic [7:0] d;
      logic       ok;
      foreach (c[i])
         emit({c[i], ~c[i]}, {4'h5, c[i]});
      u_host_model.wr_rd(8'h10, 8'hf3, d, ok);
      if (!ok)
      begin
         fails++;
         end_sim();
      end
      else
         chk_byte(d, 8'h03);
      rdchk(8'h0f, 8'hf0);
      $display("test emitters done");
   endtask

   task automatic t_window();
      u_host_model.wr(8'h0d, 8'h00);
      u_host_model.wr(8'h0e, 8'h01);
      rdchk(8'h0e, 8'h01);
      chk_word(upper, 16'h0100);
      ce = 1'b0;
      u_host_model.wr(8'h0d, 8'haa);
      ce = 1'b1;
      rdchk(8'h0d, 8'h00);
      win(1'b0, 16'h0101, 16'h0050, 1'b1);
      win(1'b0, 16'h0100, 16'h0000, 1'b0);
      win(1'b1, 16'h0005, 16'h0050, 1'b0);
      win(1'b1, 16'h0050, 16'h000f, 1'b1);
      $display("test window done");
   endtask

   task automatic t_revisions();
      old = 1'b1;
      low = 16'h0000;
      u_host_model.wr(8'h0d, 8'h41);
      u_host_model.wr(8'h0e, 8'h00);
      chk_word(upper, 16'h0041);
      win(1'b0, 16'h0012, 16'h0000, 1'b1);
      win(1'b0, 16'h0011, 16'h0000, 1'b0);
      u_host_model.wr(8'h0d, 8'h00);
      win(1'b0, 16'h0001, 16'h0000, 1'b1);
      old = 1'b0;
      seq = 1'b0;
      u_host_model.wr(8'h0d, 8'h55);
      rdchk(8'h0d, 8'h00);
      win(1'b0, 16'hfff0, 16'h0000, 1'b0);
      seq = 1'b1;
      $display("test revisions done");
   endtask

   initial
   begin
      repeat (4) @(negedge clk);
      chk_bit(event_out, 1'b0);
      rst = 1'b0;
      @(negedge clk);
      t_reset();
      t_emitters();
      t_window();
      t_revisions();
      end_sim();
   end
endmodule // als_upper_threshold_and_led_current_regs_bench
